// [core/sync_burst_sram_control.sv]
/*
  command decode and burst control of a synchronous burst sram.
  decodes the sampled control pins into read, write, continue,
  abort, deselect and stall, drives the core address, write lane
  strobes and data bus enable with one or two cycles of latency.
  assumes the memory core and the bidirectional pad sit outside;
  the controller shares sys_clk_i.
*/
// Overview of operation
// - enabled load with read starts read burst
// - advance continues burst, keeps direction
// - read with output enable high: no drive
// - enabled load, write, some lane: write burst
// - write with no lanes is an abort
// - empty write continue stores nothing, still advances
// - inactive chip select on load deselects device
// - continue after deselect stays deselected
// - clock enable high freezes all state
// - stall keeps read bus driven, write floated
// - drivers off during write cycles automatically
// - output enable and sleep act asynchronously
// - sleep floats outputs, ignores other inputs
// - outputs floated from reset onward
// - 2-bit counter on low address bits
// - counter wraps after four accesses
// - burst order pin selects linear or interleaved
// - linear order counts up modulo four
// - latency select: low flow, high pipelined
// - load takes pins, advance uses counter
// - pipelined: two cycle read and write latency
// - flow-through: one cycle shorter latency
// - each low lane strobe writes one lane
`timescale 1ns/10ps
`include "sram_ctl_consts.svh"
module sync_burst_sram_control
  import sram_ctl_pkg::*;
#(
  parameter int ADDR_W = 20,
  parameter int LANES = 4,
  parameter int LANE_W = 9
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic clk_enable_n_i,
  input wire logic advance_load_i,
  input wire logic write_n_i,
  input wire logic [LANES-1:0] lane_strobe_n_i,
  input wire logic chip_select_a_n_i,
  input wire logic chip_select_b_i,
  input wire logic chip_select_c_n_i,
  input wire logic output_enable_n_i,
  input wire logic sleep_request_i,
  input wire logic burst_order_select_i,
  input wire logic latency_select_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [LANES*LANE_W-1:0] dq_i,
  input wire logic [LANES*LANE_W-1:0] core_rdata_i,
  output logic [ADDR_W-1:0] core_addr_o,
  output logic core_rd_o,
  output logic [LANES-1:0] core_wr_lane_o,
  output logic [LANES*LANE_W-1:0] core_wdata_o,
  output logic [LANES*LANE_W-1:0] dq_o,
  output logic dq_oe_o,
  output logic sleep_o
);
  localparam int DW = LANES * LANE_W;

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  // sleep and output enable are used raw: they act asynchronously
  // on the drivers, so no sampling stages in their path
  logic stall;
  logic selected;
  logic any_lane;
  logic do_load;
  logic do_adv;
  burst_dir_e dir_r;
  burst_dir_e dir_nxt;
  logic [ADDR_W-1:0] hi_addr_r;
  logic [ADDR_W-1:0] hi_addr_nxt;
  burst_addr_t low_addr;
  logic wr_now;
  logic [LANES-1:0] lanes_now;

  // sleep blocks every other input
  assign stall = clk_enable_n_i | sleep_request_i;
  assign selected = !chip_select_a_n_i && chip_select_b_i
                    && !chip_select_c_n_i;
  assign any_lane = |(~lane_strobe_n_i);
  assign do_load = !stall && !advance_load_i;
  assign do_adv = !stall && advance_load_i
                  && (dir_r != ST_DESEL);

  always_comb
  begin
    dir_nxt = dir_r;
    hi_addr_nxt = hi_addr_r;
    if (do_load)
    begin
      if (!selected)
        dir_nxt = ST_DESEL;
      else if (write_n_i)
        dir_nxt = ST_READ;
      else
        dir_nxt = ST_WRITE;
      if (selected)
        hi_addr_nxt = addr_i;
    end
    // continue cycles leave direction as is, chip selects ignored
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      dir_r <= ST_DESEL;
      hi_addr_r <= '0;
    end
    else
    begin
      dir_r <= dir_nxt;
      hi_addr_r <= hi_addr_nxt;
    end
  end

  // ---------------------------------------------------------------
  // burst address counter
  // ---------------------------------------------------------------
  // a load with an abort (no lanes) still loads; harmless since the
  // following continue cycles derive from it consistently
  burst_addr_gen u_burst
  (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .load_i(do_load && selected),
    .advance_i(do_adv),
    .interleave_i(burst_order_select_i),
    .start_i(addr_i[`BURST_CNT_W-1:0]),
    .addr_o(low_addr)
  );

  // ---------------------------------------------------------------
  // access issue, one cycle after the command edge
  // ---------------------------------------------------------------
  logic issue_rd_r;
  logic issue_rd_nxt;
  logic issue_wr_r;
  logic issue_wr_nxt;
  logic [LANES-1:0] issue_lane_r;
  logic [LANES-1:0] issue_lane_nxt;
  logic [ADDR_W-1:0] iss_addr;

  always_comb
  begin
    issue_rd_nxt = issue_rd_r;
    issue_wr_nxt = issue_wr_r;
    issue_lane_nxt = issue_lane_r;
    if (!stall)
    begin
      issue_rd_nxt = 1'b0;
      issue_wr_nxt = 1'b0;
      issue_lane_nxt = '0;
      if (do_load && selected && write_n_i)
        issue_rd_nxt = 1'b1;
      else if (do_load && selected && any_lane)
      begin
        issue_wr_nxt = 1'b1;
        issue_lane_nxt = ~lane_strobe_n_i;
      end
      else if (do_adv && dir_r == ST_READ)
        issue_rd_nxt = 1'b1;
      else if (do_adv && dir_r == ST_WRITE && any_lane)
      begin
        issue_wr_nxt = 1'b1;
        issue_lane_nxt = ~lane_strobe_n_i;
      end
      // write with no lane: nothing issued, abort
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      issue_rd_r <= 1'b0;
      issue_wr_r <= 1'b0;
      issue_lane_r <= '0;
    end
    else
    begin
      issue_rd_r <= issue_rd_nxt;
      issue_wr_r <= issue_wr_nxt;
      issue_lane_r <= issue_lane_nxt;
    end
  end

  assign iss_addr = {hi_addr_r[ADDR_W-1:`BURST_CNT_W], low_addr};
  assign wr_now = issue_wr_r && !stall;
  assign lanes_now = issue_lane_r;

  // ---------------------------------------------------------------
  // latency pipes for read and write
  // ---------------------------------------------------------------
  // write strobes and address travel together so data arriving at
  // the late edge meets the right lanes and address
  logic wr_vld;
  logic [ADDR_W+LANES-1:0] wr_ctl;
  logic rd_vld;
  logic [DW-1:0] rd_dat;
  logic [ADDR_W+LANES-1:0] wr_ctl_in;

  assign wr_ctl_in = {iss_addr, lanes_now};
  // read access stands through a stall; the pins of the next edge
  // must not cut it short
  assign core_rd_o = issue_rd_r;

  // write pipe delays the command to the data edge
  sram_data_pipe #(.W(ADDR_W + LANES)) u_wr_pipe
  (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .hold_i(stall),
    .pipelined_i(latency_select_i),
    .vld_i(wr_now),
    .dat_i(wr_ctl_in),
    .vld_o(wr_vld),
    .dat_o(wr_ctl)
  );

  // read data taken from the core in the issue cycle; pipelined registers it one edge later
  sram_data_pipe #(.W(DW)) u_rd_pipe
  (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .hold_i(stall),
    .pipelined_i(latency_select_i),
    .vld_i(issue_rd_r),
    .dat_i(core_rdata_i),
    .vld_o(rd_vld),
    .dat_o(rd_dat)
  );

  // ---------------------------------------------------------------
  // core write and data bus drivers
  // ---------------------------------------------------------------
  // the write pipe's address overrides the issue address in the
  // write cycle; a real core would port these separately
  // single core port: a late write owns the address in its data cycle,
  // so a read issued in that same cycle would see the write address
  assign core_addr_o = wr_vld ? wr_ctl[ADDR_W+LANES-1:LANES]
                              : iss_addr;
  assign core_wr_lane_o = (wr_vld && !stall)
                          ? wr_ctl[LANES-1:0] : '0;
  assign core_wdata_o = dq_i;
  assign dq_o = rd_dat;
  // rd_vld is cleared by reset so nothing drives before a command;
  // writes never set it, so drivers stay off in write cycles
  assign dq_oe_o = rd_vld && !output_enable_n_i
                   && !sleep_request_i;
  assign sleep_o = sleep_request_i;
endmodule // sync_burst_sram_control

// [core/sram_ctl_consts.svh]
/*
  shared constants of the synchronous burst sram control block.
  assumes inclusion by bare name from the package and the modules.
*/
`ifndef SRAM_CTL_CONSTS_SVH
`define SRAM_CTL_CONSTS_SVH
`define BURST_CNT_W 2
`define BURST_STEP_LAST 2'h3
`define BURST_STEP_RST 2'h0
`define LANE_NONE_N 1'b1
`define PIPE_LAT_CYC 2
`define FLOW_LAT_CYC 1
`endif

// [core/sram_ctl_pkg.sv]
/*
  types for the synchronous burst sram control block.
  assumes the constants header is on the include path.
*/
`include "sram_ctl_consts.svh"
package sram_ctl_pkg;
  typedef enum logic [1:0] {
    ST_DESEL,
    ST_READ,
    ST_WRITE
  } burst_dir_e;
  typedef logic [`BURST_CNT_W-1:0] burst_addr_t;
endpackage

// [core/burst_addr_gen.sv]
/*
  burst address sequencer: 2-bit step counter with linear or
  interleaved order applied to the loaded low address bits.
  assumes load and advance are qualified by the caller.
*/
`timescale 1ns/10ps
`include "sram_ctl_consts.svh"
module burst_addr_gen
  import sram_ctl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic load_i,
  input wire logic advance_i,
  input wire logic interleave_i,
  input wire burst_addr_t start_i,
  output burst_addr_t addr_o
);
  burst_addr_t base_r;
  burst_addr_t base_nxt;
  burst_addr_t step_r;
  burst_addr_t step_nxt;

  always_comb
  begin
    base_nxt = base_r;
    step_nxt = step_r;
    if (load_i)
    begin
      base_nxt = start_i;
      step_nxt = `BURST_STEP_RST;
    end
    else if (advance_i)
    begin
      // modulo four; fifth access repeats the first
      step_nxt = step_r + 2'h1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      base_r <= `BURST_STEP_RST;
      step_r <= `BURST_STEP_RST;
    end
    else
    begin
      base_r <= base_nxt;
      step_r <= step_nxt;
    end
  end

  // linear adds the step, interleaved xors it
  assign addr_o = interleave_i ? (base_r ^ step_r)
                               : burst_addr_t'(base_r + step_r);
endmodule // burst_addr_gen

// [core/sram_data_pipe.sv]
/*
  data latency pipe: passes a strobe and its payload straight through
  (flow-through) or one edge late (pipelined); holds when stalled.
  assumes the caller freezes it on clock-enable stalls.
*/
`timescale 1ns/10ps
module sram_data_pipe #(
  parameter int W = 8
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic hold_i,
  input wire logic pipelined_i,
  input wire logic vld_i,
  input wire logic [W-1:0] dat_i,
  output logic vld_o,
  output logic [W-1:0] dat_o
);
  logic vld_r;
  logic vld_nxt;
  logic [W-1:0] dat_r;
  logic [W-1:0] dat_nxt;

  always_comb
  begin
    vld_nxt = vld_r;
    dat_nxt = dat_r;
    if (!hold_i)
    begin
      vld_nxt = vld_i;
      dat_nxt = dat_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      vld_r <= 1'b0;
      dat_r <= '0;
    end
    else
    begin
      vld_r <= vld_nxt;
      dat_r <= dat_nxt;
    end
  end

  // flow-through must not wait an edge, so the stage is bypassed
  assign vld_o = pipelined_i ? vld_r : vld_i;
  assign dat_o = pipelined_i ? dat_r : dat_i;
endmodule // sram_data_pipe

// [testbench/sram_ctl_chk_properties.sv]
/*
  port-level properties of the burst sram control block.
  assumes it is bound to sync_burst_sram_control.
*/
`timescale 1ns/10ps
module sram_ctl_chk #(
  parameter int ADDR_W = 20,
  parameter int LANES = 4,
  parameter int LANE_W = 9
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic clk_enable_n_i,
  input wire logic advance_load_i,
  input wire logic write_n_i,
  input wire logic chip_select_a_n_i,
  input wire logic chip_select_b_i,
  input wire logic chip_select_c_n_i,
  input wire logic output_enable_n_i,
  input wire logic sleep_request_i,
  input wire logic burst_order_select_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [LANES*LANE_W-1:0] dq_i,
  input wire logic [ADDR_W-1:0] core_addr_o,
  input wire logic core_rd_o,
  input wire logic [LANES*LANE_W-1:0] core_wdata_o,
  input wire logic dq_oe_o,
  input wire logic sleep_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic go;
  logic sel;
  assign go = !clk_enable_n_i && !sleep_request_i;
  assign sel = !chip_select_a_n_i && chip_select_b_i && !chip_select_c_n_i;
  AST_SLEEP_PASS: assert property (sleep_o == sleep_request_i)
    else $error("sleep flag differs");
  AST_OE_FLOAT: assert property (output_enable_n_i |-> !dq_oe_o)
    else $error("bus driven with output enable off");
  AST_SLEEP_FLOAT: assert property (sleep_request_i |-> !dq_oe_o)
    else $error("bus driven in sleep");
  AST_WDATA: assert property (core_wdata_o == dq_i)
    else $error("write data path differs");
  AST_STALL_HOLD: assert property (clk_enable_n_i |=> $stable(core_addr_o))
    else $error("address moved in stall");
  AST_READ_LOAD: assert property (go && !advance_load_i && write_n_i && sel
    && !output_enable_n_i |=> core_rd_o && core_addr_o == $past(addr_i))
    else $error("read load wrong");
  AST_DESEL: assert property (go && !advance_load_i && !sel |=> !core_rd_o)
    else $error("read while deselected");
  AST_LIN_STEP: assert property (go && core_rd_o && advance_load_i
    && !burst_order_select_i
    |=> core_addr_o[1:0] == $past(core_addr_o[1:0]) + 2'h1)
    else $error("linear step wrong");
endmodule // sram_ctl_chk
bind sync_burst_sram_control sram_ctl_chk #(.ADDR_W(ADDR_W),
  .LANES(LANES), .LANE_W(LANE_W)) sram_ctl_chk_inst (.*);

// [testbench/sram_core_model.sv]
/*
  memory core model: sixteen words behind the core port.
  assumes only the four low address bits matter.
*/
`timescale 1ns/10ps
module sram_core_model (
  input wire logic sys_clk_i,
  input wire logic [19:0] addr_i,
  input wire logic [3:0] wr_lane_i,
  input wire logic [35:0] wdata_i,
  output logic [35:0] rdata_o
);
  logic [35:0] mem [16] = '{default: '0};
  always @(posedge sys_clk_i)
    for (int l = 0; l < 4; l++)
      if (wr_lane_i[l])
        mem[addr_i[3:0]][l*9+:9] <= wdata_i[l*9+:9];
  assign rdata_o = mem[addr_i[3:0]];
endmodule // sram_core_model

// [testbench/sync_burst_sram_control_tb.sv]
/*
  testbench: write, abort, deselect and read bursts with random
  stalls and sleep, both latencies and both burst orders.
  assumes the core model answers reads combinationally.
*/
`timescale 1ns/10ps
module sync_burst_sram_control_tb;
  import sram_ctl_pkg::*;
  logic sys_clk_i = 0, arst_n_i = 0, clk_enable_n_i = 1;
  logic advance_load_i = 0, write_n_i = 1, chip_select_a_n_i = 1;
  logic chip_select_b_i = 0, chip_select_c_n_i = 1, took = 0, oen = 0;
  logic output_enable_n_i = 0, sleep_request_i = 0;
  logic burst_order_select_i = 0, latency_select_i = 0;
  logic core_rd_o, dq_oe_o, sleep_o;
  logic [3:0] lane_strobe_n_i = 4'hf, core_wr_lane_o;
  logic [19:0] addr_i = '0, core_addr_o, a;
  logic [35:0] dq_i = '0, core_rdata_i, core_wdata_o, dq_o, dd;
  logic [35:0] sh [16] = '{default: '0};
  logic [35:0] exq [$];
  int fail_count = 0, checked = 0;
  sync_burst_sram_control sync_burst_sram_control_inst (.*);
  sram_core_model sram_core_model_inst (.sys_clk_i(sys_clk_i),
    .addr_i(core_addr_o), .wr_lane_i(core_wr_lane_o),
    .wdata_i(core_wdata_o), .rdata_o(core_rdata_i));
  initial forever #12.5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) took <= !clk_enable_n_i && !sleep_request_i;
  // ----------
  // checking
  // ----------
  task automatic chk(input logic [35:0] g, input logic [35:0] e);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic final_report;
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // a result is new only after a taken edge; stalls repeat it
  always @(negedge sys_clk_i)
    if (dq_oe_o === 1'b1 && took)
    begin
      if (exq.size() == 0)
        chk(36'h1, 36'h0);
      else
        chk(dq_o, exq.pop_front());
    end
  // ----------
  // stimulus
  // ----------
  // sleep only in the drained deselect tail, nothing pending then
  task automatic op(input logic advance_load, input logic wn, input logic [3:0] ln,
                    input logic [1:0] s, input logic [19:0] ad);
    int st;
    st = $urandom_range(0, 3);
    if (st > 1)
    begin
      @(posedge sys_clk_i);
      clk_enable_n_i <= !(st == 3 && s > 2'd1);
      sleep_request_i <= st == 3 && s > 2'd1;
    end
    @(posedge sys_clk_i);
    clk_enable_n_i <= 0;
    sleep_request_i <= 0;
    output_enable_n_i <= oen;
    advance_load_i <= advance_load;
    write_n_i <= wn;
    lane_strobe_n_i <= ln;
    chip_select_a_n_i <= s == 2'd1;
    chip_select_b_i <= s != 2'd2;
    chip_select_c_n_i <= s == 2'd3;
    addr_i <= ad;
  endtask
  task automatic burst(input logic wr, input logic [19:0] ad);
    logic [3:0] ln;
    logic [3:0] ix;
    for (int k = 0; k < 5; k++)
    begin
      ix = {ad[3:2], burst_order_select_i ? ad[1:0] ^ k[1:0]
                                          : ad[1:0] + k[1:0]};
      ln = wr ? 4'($urandom) : 4'hf;
      if (wr && k == 0 && ln == 4'hf)
        ln = 4'h7;
      for (int l = 0; l < 4; l++)
        if (!ln[l])
          sh[ix][l*9+:9] = dd[l*9+:9];
      if (!wr && !oen)
        exq.push_back(sh[ix]);
      op(k != 0, !wr, ln, 2'd0, ad);
    end
    for (int k = 0; k < 4; k++)
      op(k == 1, !wr, 4'h0, k == 0 ? 2'd1 : 2'(k), ad);
  endtask
  initial
  begin
    void'($urandom(60));
    for (int r = 0; r < 4; r++)
    begin
      @(posedge sys_clk_i);
      arst_n_i <= 0;
      latency_select_i <= r[0];
      burst_order_select_i <= r[1];
      repeat (20) @(posedge sys_clk_i);
      chk({35'h0, dq_oe_o}, 36'h0);
      arst_n_i <= 1;
      dd = 36'({$urandom, $urandom});
      dq_i <= dd;
      a = 20'($urandom);
      burst(1, a);
      op(0, 0, 4'hf, 2'd0, a ^ 20'h4);
      burst(0, a);
      burst(0, a ^ 20'h4);
      oen = 1;
      burst(0, a);
      oen = 0;
    end
    chk({35'h0, exq.size() == 0}, 36'h1);
    final_report;
  end
  initial
  begin
    repeat (5000) @(posedge sys_clk_i);
    fail_count++;
    final_report;
  end
endmodule // sync_burst_sram_control_tb
